/* File: rtl/gel_pkg.sv */
package gel_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] GEL_ADDR_MASK = 8'h05;
  localparam logic [7:0] GEL_ADDR_SENSE_HI = 8'h06;
  localparam logic [7:0] GEL_ADDR_SENSE_LO = 8'h07;
  localparam logic [7:0] GEL_ADDR_SRC = 8'h08;
  localparam logic [7:0] GEL_ADDR_EVT = 8'h09;
  localparam logic [7:0] GEL_ADDR_MODE = 8'h10;
  localparam logic [7:0] GEL_ADDR_TBL0 = 8'h11;
  localparam logic [7:0] GEL_ADDR_TBL1 = 8'h12;
  localparam logic [7:0] GEL_ADDR_TBL2 = 8'h13;
  localparam logic [7:0] GEL_ADDR_TBL3A = 8'h14;
  localparam logic [7:0] GEL_ADDR_TBL3B = 8'h15;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] GEL_RST_MASK = 8'hff;
  localparam logic [7:0] GEL_RST_SENSE = 8'h00;
  localparam logic [7:0] GEL_RST_FLAGS = 8'h00;
  localparam logic [7:0] GEL_RST_MODE = 8'h00;
  localparam logic [7:0] GEL_RST_TBL = 8'h00;

  // ----------------------------------------------------------------
  // Field positions of the logic decode mode register
  // ----------------------------------------------------------------
  localparam int GEL_MODE_HI_LSB = 4;
  localparam int GEL_MODE_LO_LSB = 0;
  localparam logic [7:0] GEL_MODE_WR_MASK = 8'h33;
  // Two-to-one table: upper nibble decodes lines 5:4, lower lines 1:0
  localparam int GEL_TBL0_HI_LSB = 4;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    GEL_SENSE_NONE = 2'h0,
    GEL_SENSE_RISE = 2'h1,
    GEL_SENSE_FALL = 2'h2,
    GEL_SENSE_BOTH = 2'h3
  } gel_sense_type;

  typedef enum logic [1:0] {
    GEL_MODE_GPIO = 2'h0,
    GEL_MODE_2TO1 = 2'h1,
    GEL_MODE_3TO1 = 2'h2,
    GEL_MODE_3TO2 = 2'h3
  } gel_mode_type;

endpackage

/* File: rtl/gel_edge_det.sv */
`timescale 1ns/1ps

module gel_edge_det
  import gel_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Pin and setting
  input wire logic i_pin,
  input wire logic [1:0] i_sense,
  // Results
  output logic o_level,
  output logic o_hit
);

  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic level_q;
  logic level_d;
  logic hit_q;
  logic hit_d;
  logic rise;
  logic fall;

  // Level moves only when the second and third stage agree
  always_comb begin
    sync_d = {sync_q[1:0], i_pin};
    level_d = level_q;
    if (sync_q[1] == sync_q[2]) begin
      level_d = sync_q[2];
    end
    rise = level_d & ~level_q;
    fall = ~level_d & level_q;
    unique case (gel_sense_type'(i_sense))
      GEL_SENSE_NONE: hit_d = 1'b0;
      GEL_SENSE_RISE: hit_d = rise;
      GEL_SENSE_FALL: hit_d = fall;
      GEL_SENSE_BOTH: hit_d = rise | fall;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_q <= 3'h0;
      level_q <= 1'b0;
      hit_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      level_q <= level_d;
      hit_q <= hit_d;
    end
  end

  assign o_level = level_q;
  assign o_hit = hit_q;

endmodule

/* File: rtl/gel_top.sv */
// Summary of operation
// - Lines 1 and 0 have two-bit sense fields at 3:2 and 1:0; 11 both.
// - Sense 00 none, 01 rising only, 10 falling only, per line.
// - Mask bit 0 lets a line interrupt; mask bit 1 suppresses it.
// - Unmasked matching edge sets the line's interrupt-origin flag.
// - Writing one to an origin flag clears it and its event flag.
// - Interrupt output returns high once all origin flags are clear.
// - Any matching edge, masked or not, sets the line's event flag.
// - Writing one to an event flag clears it and its origin flag.
// - Upper mode field 5:4 controls lines 7:4; 00 GPIO, 11 reserved.
// - Upper mode 01 drives line 6 from table zero by lines 5:4.
// - Upper mode 10 drives line 7 from table one by lines 6:4.
// - Lower mode field 1:0 controls lines 4:0; 00 is GPIO.
// - Lower mode 01 drives line 2 from table zero by lines 1:0.
// - Lower mode 10 drives line 3 from table two by lines 2:0.
// - Lower mode 11 drives lines 4 and 3 from table three by 2:0.
// - Table zero bits 7..4 give line 6 for inputs 11,10,01,00.
`timescale 1ns/1ps

module gel_top
  import gel_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // Ordinary GPIO drive from the data and direction registers
  input wire logic [7:0] i_gpio_dout,
  input wire logic [7:0] i_gpio_oe,
  // IO lines
  input wire logic [7:0] i_io,
  output logic [7:0] o_io,
  output logic [7:0] o_io_oe,
  // Open-drain interrupt
  output logic o_irq_out_n,
  output logic o_irq_out_n_oe
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  logic [15:0] sense;
  logic [7:0] lvl;
  logic [7:0] hit;

  for (genvar g = 0; g < 8; g++) begin : g_line
    gel_edge_det u_edge (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_pin(i_io[g]),
      .i_sense(sense[2*g +: 2]),
      .o_level(lvl[g]),
      .o_hit(hit[g])
    );
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [7:0] mask_q;
  logic [7:0] mask_d;
  logic [7:0] sense_hi_q;
  logic [7:0] sense_hi_d;
  logic [7:0] sense_lo_q;
  logic [7:0] sense_lo_d;
  logic [7:0] mode_q;
  logic [7:0] mode_d;
  logic [7:0] tbl0_q;
  logic [7:0] tbl0_d;
  logic [7:0] tbl1_q;
  logic [7:0] tbl1_d;
  logic [7:0] tbl2_q;
  logic [7:0] tbl2_d;
  logic [7:0] tbl3a_q;
  logic [7:0] tbl3a_d;
  logic [7:0] tbl3b_q;
  logic [7:0] tbl3b_d;

  always_comb begin
    mask_d = mask_q;
    sense_hi_d = sense_hi_q;
    sense_lo_d = sense_lo_q;
    mode_d = mode_q;
    tbl0_d = tbl0_q;
    tbl1_d = tbl1_q;
    tbl2_d = tbl2_q;
    tbl3a_d = tbl3a_q;
    tbl3b_d = tbl3b_q;
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        GEL_ADDR_MASK: mask_d = i_reg_wdata;
        GEL_ADDR_SENSE_HI: sense_hi_d = i_reg_wdata;
        GEL_ADDR_SENSE_LO: sense_lo_d = i_reg_wdata;
        // Reserved bits are not stored so they always read zero
        GEL_ADDR_MODE: mode_d = i_reg_wdata & GEL_MODE_WR_MASK;
        GEL_ADDR_TBL0: tbl0_d = i_reg_wdata;
        GEL_ADDR_TBL1: tbl1_d = i_reg_wdata;
        GEL_ADDR_TBL2: tbl2_d = i_reg_wdata;
        GEL_ADDR_TBL3A: tbl3a_d = i_reg_wdata;
        GEL_ADDR_TBL3B: tbl3b_d = i_reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= GEL_RST_MASK;
      sense_hi_q <= GEL_RST_SENSE;
      sense_lo_q <= GEL_RST_SENSE;
      mode_q <= GEL_RST_MODE;
      tbl0_q <= GEL_RST_TBL;
      tbl1_q <= GEL_RST_TBL;
      tbl2_q <= GEL_RST_TBL;
      tbl3a_q <= GEL_RST_TBL;
      tbl3b_q <= GEL_RST_TBL;
    end else begin
      mask_q <= mask_d;
      sense_hi_q <= sense_hi_d;
      sense_lo_q <= sense_lo_d;
      mode_q <= mode_d;
      tbl0_q <= tbl0_d;
      tbl1_q <= tbl1_d;
      tbl2_q <= tbl2_d;
      tbl3a_q <= tbl3a_d;
      tbl3b_q <= tbl3b_d;
    end
  end

  assign sense = {sense_hi_q, sense_lo_q};

  // ----------------------------------------------------------------
  // Event and interrupt-origin flags
  // ----------------------------------------------------------------
  logic [7:0] evt_q;
  logic [7:0] evt_d;
  logic [7:0] src_q;
  logic [7:0] src_d;
  logic [7:0] clr;
  logic [15:0] sense_new;

  always_comb begin
    clr = 8'h00;
    sense_new = {sense_hi_d, sense_lo_d};
    if (i_reg_wr && (i_reg_addr == GEL_ADDR_SRC ||
                     i_reg_addr == GEL_ADDR_EVT)) begin
      clr = i_reg_wdata;
    end
    for (int i = 0; i < 8; i++) begin
      if (sense_new[2*i +: 2] != sense[2*i +: 2]) begin
        clr[i] = 1'b1;
      end
    end
    // A new edge in the clearing cycle is kept: set beats clear
    evt_d = (evt_q & ~clr) | hit;
    src_d = (src_q & ~clr) | (hit & ~mask_q);
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_q <= GEL_RST_FLAGS;
      src_q <= GEL_RST_FLAGS;
    end else begin
      evt_q <= evt_d;
      src_q <= src_d;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pin
  // ----------------------------------------------------------------
  logic irq_q;
  logic irq_d;

  always_comb begin
    irq_d = |src_q;
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // Open drain: only ever pulls low, never drives high
  assign o_irq_out_n = 1'b0;
  assign o_irq_out_n_oe = irq_q;

  // ----------------------------------------------------------------
  // Logic decode
  // ----------------------------------------------------------------
  logic [7:0] io_d;
  logic [7:0] io_q;
  logic [7:0] oe_d;
  logic [7:0] oe_q;
  logic [1:0] mode_hi;
  logic [1:0] mode_lo;
  logic [2:0] idx_hi2;
  logic [2:0] idx_lo2;

  always_comb begin
    io_d = i_gpio_dout;
    oe_d = i_gpio_oe;
    mode_hi = mode_q[GEL_MODE_HI_LSB +: 2];
    mode_lo = mode_q[GEL_MODE_LO_LSB +: 2];
    idx_hi2 = 3'(GEL_TBL0_HI_LSB) + {1'b0, lvl[5:4]};
    idx_lo2 = {1'b0, lvl[1:0]};
    unique case (gel_mode_type'(mode_hi))
      GEL_MODE_GPIO: ;
      GEL_MODE_2TO1: begin
        io_d[6] = tbl0_q[idx_hi2];
        oe_d[6] = 1'b1;
      end
      GEL_MODE_3TO1: begin
        io_d[7] = tbl1_q[lvl[6:4]];
        oe_d[7] = 1'b1;
      end
      GEL_MODE_3TO2: ;
    endcase
    // Lower mode wins on line 4 since the upper modes never drive it
    unique case (gel_mode_type'(mode_lo))
      GEL_MODE_GPIO: ;
      GEL_MODE_2TO1: begin
        io_d[2] = tbl0_q[idx_lo2];
        oe_d[2] = 1'b1;
      end
      GEL_MODE_3TO1: begin
        io_d[3] = tbl2_q[lvl[2:0]];
        oe_d[3] = 1'b1;
      end
      GEL_MODE_3TO2: begin
        io_d[3] = tbl3a_q[lvl[2:0]];
        io_d[4] = tbl3b_q[lvl[2:0]];
        oe_d[4:3] = 2'h3;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_q <= 8'h00;
      oe_q <= 8'h00;
    end else begin
      io_q <= io_d;
      oe_q <= oe_d;
    end
  end

  assign o_io = io_q;
  assign o_io_oe = oe_q;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  always_comb begin
    rdata_d = rdata_q;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        GEL_ADDR_MASK: rdata_d = mask_q;
        GEL_ADDR_SENSE_HI: rdata_d = sense_hi_q;
        GEL_ADDR_SENSE_LO: rdata_d = sense_lo_q;
        GEL_ADDR_SRC: rdata_d = src_q;
        GEL_ADDR_EVT: rdata_d = evt_q;
        GEL_ADDR_MODE: rdata_d = mode_q;
        GEL_ADDR_TBL0: rdata_d = tbl0_q;
        GEL_ADDR_TBL1: rdata_d = tbl1_q;
        GEL_ADDR_TBL2: rdata_d = tbl2_q;
        GEL_ADDR_TBL3A: rdata_d = tbl3a_q;
        GEL_ADDR_TBL3B: rdata_d = tbl3b_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_reg_rdata = rdata_q;

endmodule

/* File: tb/gel_top_asserts.sv */
`timescale 1ns/1ps

module gel_top_asserts
  import gel_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  // Lines
  input wire logic [7:0] i_gpio_dout,
  input wire logic [7:0] i_gpio_oe,
  input wire logic [7:0] i_io,
  input wire logic [7:0] o_io,
  input wire logic [7:0] o_io_oe,
  input wire logic o_irq_out_n,
  input wire logic o_irq_out_n_oe
);
  logic [2:0] up_q;
  logic [3:0] quiet_q;
  logic [7:0] io_q;
  logic clr;

  // Internal reset lags the pin by two flops, so wait three edges
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      up_q <= 3'h0;
      quiet_q <= 4'h0;
      io_q <= 8'h00;
    end else begin
      up_q <= {up_q[1:0], 1'b1};
      io_q <= i_io;
      quiet_q <= (i_io != io_q) ? 4'h0 : quiet_q + {3'h0, ~&quiet_q};
    end
  end

  assign clr = i_reg_wr && (i_reg_addr inside {GEL_ADDR_SENSE_HI,
    GEL_ADDR_SENSE_LO, GEL_ADDR_SRC, GEL_ADDR_EVT});

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn || !up_q[2]);

  a_irq_pin_low:
    assert property (o_irq_out_n == 1'b0) else $error("irq data not low");
  a_irq_sticky:
    assert property (o_irq_out_n_oe && !clr && !$past(clr)
      |=> o_irq_out_n_oe) else $error("irq dropped without clear");
  a_irq_cause:
    assert property ($rose(o_irq_out_n_oe) |-> quiet_q < 4'h9)
    else $error("irq without recent pin edge");
  a_src_release:
    assert property ($stable(i_io)[*6] ##0 (i_reg_wr && i_reg_wdata == 8'hff
      && i_reg_addr == GEL_ADDR_SRC) |-> ##2 !o_irq_out_n_oe)
    else $error("irq held after source clear");
  a_evt_release:
    assert property ($stable(i_io)[*6] ##0 (i_reg_wr && i_reg_wdata == 8'hff
      && i_reg_addr == GEL_ADDR_EVT) |-> ##2 !o_irq_out_n_oe)
    else $error("irq held after event clear");
  a_mode_reserved:
    assert property (i_reg_rd && i_reg_addr == GEL_ADDR_MODE
      |-> ##1 (o_reg_rdata & 8'hcc) == 8'h00) else $error("mode bits set");
  a_gpio_low:
    assert property (o_io[1:0] == $past(i_gpio_dout[1:0])
      && o_io_oe[1:0] == $past(i_gpio_oe[1:0])) else $error("low gpio");
  a_gpio_mid:
    assert property (o_io[5] == $past(i_gpio_dout[5])) else $error("line 5");

  c_irq_set: cover property ($rose(o_irq_out_n_oe));
  c_irq_clr: cover property ($fell(o_irq_out_n_oe));
  c_mode_rd: cover property (i_reg_rd && i_reg_addr == GEL_ADDR_MODE);
endmodule

bind gel_top gel_top_asserts gel_top_asserts_inst (.*);

/* File: tb/gel_host.sv */
`timescale 1ns/1ps

module gel_host
  import gel_pkg::*;
(
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  initial begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  // Released bus shows inverted values so stale data is never trusted
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= (a == GEL_ADDR_MODE) ? (d & GEL_MODE_WR_MASK) : d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    @(posedge i_clk);
    #1;
    d = i_rdata;
  endtask
endmodule

/* File: tb/gel_top_test.sv */
`timescale 1ns/1ps

module gel_top_test;
  import gel_pkg::*;
  logic clk = 1'b0;
  logic rstn;
  logic [7:0] addr, wdata, rdata, gdout, goe, io, o_io, o_oe;
  logic wr, rd, irq_n, irq_oe;
  int num_errors = 0;
  int cmp_count = 0;

  gel_top gel_top_inst (.i_clk(clk), .i_rstn(rstn), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .i_gpio_dout(gdout), .i_gpio_oe(goe), .i_io(io), .o_io(o_io),
    .o_io_oe(o_oe), .o_irq_out_n(irq_n), .o_irq_out_n_oe(irq_oe));
  gel_host gel_host_inst (.i_clk(clk), .i_rdata(rdata), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic chk(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    gel_host_inst.rd(a, v);
    chk($sformatf("reg %h", a), v, exp);
  endtask

  // Pin settles through sync, level and flag stages well within 8 edges
  task automatic pin(input logic [7:0] v);
    @(posedge clk);
    io <= v;
    repeat (8) @(posedge clk);
    #1;
  endtask

  task automatic t_reset();
    rchk(GEL_ADDR_MASK, 8'hff);
    rchk(GEL_ADDR_SRC, 8'h00);
    rchk(GEL_ADDR_EVT, 8'h00);
    rchk(GEL_ADDR_MODE, 8'h00);
    rchk(GEL_ADDR_TBL0, 8'h00);
    chk("irq", {7'h0, irq_oe}, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_sense();
    for (int c = 0; c < 4; c++) begin
      gel_host_inst.wr(GEL_ADDR_SENSE_LO, 8'(c));
      pin(8'h01);
      rchk(GEL_ADDR_EVT, {7'h0, c[0]});
      rchk(GEL_ADDR_SRC, 8'h00);
      gel_host_inst.wr(GEL_ADDR_EVT, 8'h01);
      pin(8'h00);
      rchk(GEL_ADDR_EVT, {7'h0, c[1]});
      gel_host_inst.wr(GEL_ADDR_EVT, 8'h01);
    end
    $display("test sense done");
  endtask

  task automatic t_irq();
    gel_host_inst.wr(GEL_ADDR_SENSE_LO, 8'h0c);
    gel_host_inst.wr(GEL_ADDR_MASK, 8'hfd);
    pin(8'h02);
    rchk(GEL_ADDR_SRC, 8'h02);
    chk("irq", {7'h0, irq_oe}, 8'h01);
    gel_host_inst.wr(GEL_ADDR_SRC, 8'h01);
    rchk(GEL_ADDR_EVT, 8'h02);
    gel_host_inst.wr(GEL_ADDR_SRC, 8'hff);
    rchk(GEL_ADDR_EVT, 8'h00);
    chk("irq", {7'h0, irq_oe}, 8'h00);
    pin(8'h00);
    rchk(GEL_ADDR_SRC, 8'h02);
    gel_host_inst.wr(GEL_ADDR_EVT, 8'hff);
    rchk(GEL_ADDR_SRC, 8'h00);
    pin(8'h02);
    gel_host_inst.wr(GEL_ADDR_SENSE_LO, 8'h04);
    rchk(GEL_ADDR_EVT, 8'h00);
    chk("irq", {7'h0, irq_oe}, 8'h00);
    $display("test irq done");
  endtask

  localparam logic [7:0] T0 = 8'hb4;
  localparam logic [7:0] T1 = 8'h96;
  localparam logic [7:0] T2 = 8'h3c;
  localparam logic [7:0] T3 = 8'he1;
  localparam logic [7:0] T4 = 8'h78;

  // Sparse GPIO enables so decoded lines show up as extra drive bits
  task automatic t_decode();
    @(posedge clk);
    gdout <= 8'h5a;
    goe <= 8'h21;
    pin(8'h00);
    chk("gpio", o_io, 8'h5a);
    chk("gpio oe", o_oe, 8'h21);
    gel_host_inst.wr(GEL_ADDR_TBL0, T0);
    gel_host_inst.wr(GEL_ADDR_MODE, 8'h11);
    for (int i = 0; i < 4; i++) begin
      pin({2'h0, 2'(i), 2'h0, 2'(i)});
      chk("line6", {7'h0, o_io[6]}, {7'h0, T0[4 + i]});
      chk("line2", {7'h0, o_io[2]}, {7'h0, T0[i]});
      chk("oe 2to1", o_oe, 8'h65);
    end
    gel_host_inst.wr(GEL_ADDR_TBL1, T1);
    gel_host_inst.wr(GEL_ADDR_TBL2, T2);
    gel_host_inst.wr(GEL_ADDR_MODE, 8'h22);
    for (int i = 0; i < 8; i++) begin
      pin({1'b0, 3'(i), 1'b0, 3'(i)});
      chk("line7", {7'h0, o_io[7]}, {7'h0, T1[i]});
      chk("line3", {7'h0, o_io[3]}, {7'h0, T2[i]});
      chk("oe 3to1", o_oe, 8'ha9);
    end
    gel_host_inst.wr(GEL_ADDR_TBL3A, T3);
    gel_host_inst.wr(GEL_ADDR_TBL3B, T4);
    // Upper field 11 is reserved and must leave lines 7:5 as GPIO
    gel_host_inst.wr(GEL_ADDR_MODE, 8'h33);
    rchk(GEL_ADDR_MODE, 8'h33);
    for (int i = 0; i < 8; i++) begin
      pin({5'h0, 3'(i)});
      chk("line3", {7'h0, o_io[3]}, {7'h0, T3[i]});
      chk("line4", {7'h0, o_io[4]}, {7'h0, T4[i]});
      chk("upper gpio", {5'h0, o_io[7:5]}, 8'h02);
      chk("oe 3to2", o_oe, 8'h39);
    end
    $display("test decode done");
  endtask

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_of_test();
  end

  initial begin
    rstn = 1'b0;
    gdout = 8'h00;
    goe = 8'h00;
    io = 8'h00;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_sense();
    t_irq();
    t_decode();
    end_of_test();
  end
endmodule
